// file: src/lro_core.sv
// latch and restart operators with an ahb-lite register slave
//
// Overview of operation
// - data flip-flop loads data on capture edge
// - preset forces one, clear forces zero, clear wins
// - sixteen data and sixteen toggle flip-flops
// - toggle flip-flop inverts on each rising toggle
// - optional toggle clear resets output to zero
// - set/reset latch, reset dominant, else hold
// - retained latch stores on change, reloads at power-up
// - manual restart: cleared or blocked gives zero
// - monitored restart sets on full restart pulse
// - optional restart clear resets stored state
// - style one request high only while waiting
// - style two request: blocked high, waiting blinks
// - restart instances: sixteen basic, thirty-two enhanced
// - condition gate one to seven inputs, one bypasses
// - restart gate one to seven inputs, one bypasses
// - gates do and, nand, or, nor, xor, xnor
// - macro manual sets on rising restart gate output
// - macro monitored sets on full restart gate pulse
// - optional output shows condition gate result
//
// Chosen here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module lro_core import lro_pkg::*; #(
	parameter longint BLINK_HALF_CYC = LRO_BLINK_HALF_CYC
) (
	input wire logic sys_clk, // system clock
	input wire logic rstn, // async reset, active low
	input wire logic hsel, // ahb slave select
	input wire logic [31:0] haddr, // ahb address
	input wire logic [1:0] htrans, // ahb transfer type
	input wire logic hwrite, // ahb write
	input wire logic [2:0] hsize, // ahb size
	input wire logic [31:0] hwdata, // ahb write data
	input wire logic hready, // ahb bus ready
	output logic hreadyout, // ahb slave ready
	output logic hresp, // ahb response
	output logic [31:0] hrdata, // ahb read data
	input wire logic [LRO_DFF_N-1:0] dff_data_in, // data inputs
	input wire logic [LRO_DFF_N-1:0] capture_edge_in, // capture clocks
	input wire logic [LRO_DFF_N-1:0] dff_preset_in, // preset inputs
	input wire logic [LRO_DFF_N-1:0] dff_clear_in, // clear inputs
	output logic [LRO_DFF_N-1:0] dff_q, // data flip-flop outputs
	input wire logic [LRO_TFF_N-1:0] tff_toggle_in, // toggle inputs
	input wire logic [LRO_TFF_N-1:0] tff_clear_in, // toggle clears
	output logic [LRO_TFF_N-1:0] tff_q, // toggle outputs
	input wire logic [LRO_SR_N-1:0] sr_set_in, // latch set inputs
	input wire logic [LRO_SR_N-1:0] sr_reset_in, // latch reset inputs
	output logic [LRO_SR_N-1:0] sr_q, // latch outputs
	input wire logic [LRO_SR_N-1:0] nv_restore_in, // stored latch image
	output logic nv_write, // store strobe, one cycle
	output logic [LRO_SR_N-1:0] nv_write_data, // image to store
	input wire logic [LRO_RST_N*LRO_GATE_W-1:0] rst_cond_in, // cond gates
	input wire logic [LRO_RST_N*LRO_GATE_W-1:0] rst_cmd_in, // restart gates
	input wire logic [LRO_RST_N-1:0] rst_clear_in, // restart clears
	output logic [LRO_RST_N-1:0] rst_q, // restart outputs
	output logic [LRO_RST_N-1:0] rst_req, // restart request outputs
	output logic [LRO_RST_N-1:0] rst_cond_out // condition gate results
);

	function automatic logic lro_gate(input logic [LRO_GATE_W-1:0] in,
		input logic [2:0] cnt, input logic [2:0] fn);
		logic [LRO_GATE_W-1:0] mask;
		logic r;
		mask = '0;
		r = in[0];
		// inputs beyond the count are masked out of every function
		for (int k = 0; k < LRO_GATE_W; k++) begin
			mask[k] = (k < int'(cnt));
		end
		// a count of one (or an unused code 0) passes input one straight
		if (cnt > 3'h1) begin
			case (fn)
				LRO_G_AND: r = &(in | ~mask);
				LRO_G_NAND: r = ~&(in | ~mask);
				LRO_G_OR: r = |(in & mask);
				LRO_G_NOR: r = ~|(in & mask);
				LRO_G_XOR: r = ^(in & mask);
				LRO_G_XNOR: r = ~^(in & mask);
				default: r = &(in | ~mask);
			endcase
		end
		return r;
	endfunction

	// bus slave: zero wait states, always okay
	// writes are held one cycle: their data comes in the data phase
	logic wr_pend_reg;
	logic [11:0] wr_addr_reg;
	logic [31:0] hrdata_reg;
	logic [31:0] dff_cfg_reg;
	logic [31:0] tff_cfg_reg;
	logic [31:0] sr_cfg_reg;
	logic [LRO_RC_W-1:0] rcfg_reg [0:LRO_RST_N-1];

	wire addr_phase = hsel & htrans[1] & hready;
	wire addr_hi_ok = (haddr[31:12] == 20'h0_0000);
	wire rd_take = addr_phase & ~hwrite;
	wire wr_take = addr_phase & hwrite;
	wire [4:0] rd_idx = haddr[6:2];
	wire rd_rcfg = addr_hi_ok & (haddr[11:7] == LRO_RST_CFG_BLK);
	wire wr_rcfg = (wr_addr_reg[11:7] == LRO_RST_CFG_BLK);
	wire [4:0] wr_idx = wr_addr_reg[6:2];
	wire wr_dff = wr_pend_reg & (wr_addr_reg == LRO_DFF_CFG_OFS);
	wire wr_tff = wr_pend_reg & (wr_addr_reg == LRO_TFF_CFG_OFS);
	wire wr_sr = wr_pend_reg & (wr_addr_reg == LRO_SR_CFG_OFS);
	wire [11:0] ra = haddr[11:0];
	wire sel_dcfg = (ra == LRO_DFF_CFG_OFS);
	wire sel_tcfg = (ra == LRO_TFF_CFG_OFS);
	wire sel_scfg = (ra == LRO_SR_CFG_OFS);
	wire sel_dq = (ra == LRO_DFF_Q_OFS);
	wire sel_tq = (ra == LRO_TFF_Q_OFS);
	wire sel_sq = (ra == LRO_SR_Q_OFS);
	wire sel_rq = (ra == LRO_RST_Q_OFS);
	wire sel_rreq = (ra == LRO_RST_REQ_OFS);

	// unmapped or upper addresses read as zero
	wire [31:0] rd_word =
		!addr_hi_ok ? 32'h0000_0000 :
		rd_rcfg ? {{(32-LRO_RC_W){1'b0}}, rcfg_reg[rd_idx]} :
		sel_dcfg ? dff_cfg_reg :
		sel_tcfg ? tff_cfg_reg :
		sel_scfg ? sr_cfg_reg :
		sel_dq ? {16'h0000, dff_q} :
		sel_tq ? {16'h0000, tff_q} :
		sel_sq ? {16'h0000, sr_q} :
		sel_rq ? 32'(rst_q) :
		sel_rreq ? 32'(rst_req) : 32'h0000_0000;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	// hrdata stands until the next read address phase is taken; a read
	// right after a write to the same word returns the old value, as
	// reads are taken at the address edge and writes one edge later
	assign hrdata = hrdata_reg;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 12'h000;
			hrdata_reg <= 32'h0000_0000;
		end else begin
			wr_pend_reg <= wr_take & addr_hi_ok;
			wr_addr_reg <= haddr[11:0];
			if (rd_take) begin
				hrdata_reg <= rd_word;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			dff_cfg_reg <= LRO_CFG_RST;
			tff_cfg_reg <= LRO_CFG_RST;
			sr_cfg_reg <= LRO_CFG_RST;
			for (int k = 0; k < LRO_RST_N; k++) begin
				rcfg_reg[k] <= LRO_RC_RST;
			end
		end else begin
			if (wr_dff) begin
				dff_cfg_reg <= hwdata;
			end
			if (wr_tff) begin
				tff_cfg_reg <= {16'h0000, hwdata[15:0]};
			end
			if (wr_sr) begin
				sr_cfg_reg <= {16'h0000, hwdata[15:0]};
			end
			// bits above the field width are dropped and read back as zero
			if (wr_pend_reg & wr_rcfg) begin
				rcfg_reg[wr_idx] <= hwdata[LRO_RC_W-1:0];
			end
		end
	end

	// power-up: one load cycle before any operator is evaluated
	// data and toggle edge history still samples during boot, so their
	// first evaluated cycle compares against a real previous value
	logic boot_reg;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			boot_reg <= 1'b1;
		end else begin
			boot_reg <= 1'b0;
		end
	end

	// data and toggle flip-flops, one sample per processing cycle
	logic [LRO_DFF_N-1:0] cap_prev_reg;
	logic [LRO_DFF_N-1:0] dff_q_reg;
	logic [LRO_TFF_N-1:0] tog_prev_reg;
	logic [LRO_TFF_N-1:0] tff_q_reg;

	wire [LRO_DFF_N-1:0] pre_en = dff_cfg_reg[15:0];
	wire [LRO_DFF_N-1:0] dclr_en = dff_cfg_reg[31:16];
	wire [LRO_DFF_N-1:0] cap_rise = capture_edge_in & ~cap_prev_reg;
	wire [LRO_DFF_N-1:0] dclr = dclr_en & dff_clear_in;
	wire [LRO_DFF_N-1:0] dpre = pre_en & dff_preset_in & ~dclr;
	// clear beats preset beats capture; without any of them a bit holds
	wire [LRO_DFF_N-1:0] dff_load = cap_rise & dff_data_in;
	wire [LRO_DFF_N-1:0] dff_keep = ~cap_rise & dff_q_reg;
	wire [LRO_DFF_N-1:0] dff_q_next =
		~dclr & (dpre | dff_load | dff_keep);

	wire [LRO_TFF_N-1:0] tog_rise = tff_toggle_in & ~tog_prev_reg;
	wire [LRO_TFF_N-1:0] tclr_en = tff_cfg_reg[15:0];
	wire [LRO_TFF_N-1:0] tclr = tclr_en & tff_clear_in;
	// an enabled clear wins over a toggle in the same cycle
	wire [LRO_TFF_N-1:0] tff_q_next =
		(tff_q_reg ^ tog_rise) & ~tclr;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cap_prev_reg <= '0;
			tog_prev_reg <= '0;
			dff_q_reg <= '0;
			tff_q_reg <= '0;
		end else begin
			cap_prev_reg <= capture_edge_in;
			tog_prev_reg <= tff_toggle_in;
			if (!boot_reg) begin
				dff_q_reg <= dff_q_next;
				tff_q_reg <= tff_q_next;
			end
		end
	end
	assign dff_q = dff_q_reg;
	assign tff_q = tff_q_reg;

	// set/reset latches with optional retention
	logic [LRO_SR_N-1:0] sr_q_reg;
	logic nv_write_reg;
	logic [LRO_SR_N-1:0] nv_data_reg;
	wire [LRO_SR_N-1:0] ret_en = sr_cfg_reg[15:0];
	wire [LRO_SR_N-1:0] sr_q_next =
		(sr_q_reg | sr_set_in) & ~sr_reset_in;
	// retention enables are still at reset value during boot, so the
	// image is reloaded whole; it holds retained bits only, as every
	// store masks the others to zero
	wire [LRO_SR_N-1:0] sr_boot = nv_restore_in;
	wire sr_changed = |((sr_q_next ^ sr_q_reg) & ret_en);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sr_q_reg <= '0;
			nv_write_reg <= 1'b0;
			nv_data_reg <= '0;
		end else begin
			nv_write_reg <= 1'b0;
			if (boot_reg) begin
				sr_q_reg <= sr_boot;
			end else begin
				sr_q_reg <= sr_q_next;
				nv_write_reg <= sr_changed;
				if (sr_changed) begin
					nv_data_reg <= sr_q_next & ret_en;
				end
			end
		end
	end
	assign sr_q = sr_q_reg;
	assign nv_write = nv_write_reg;
	assign nv_write_data = nv_data_reg;

	// free-running blink base for style-two requests
	// one shared base: all waiting requests blink in phase, and the
	// first half period after a wait starts may be short
	logic [31:0] blink_cnt_reg;
	logic blink_reg;
	wire blink_wrap = (blink_cnt_reg == 32'(BLINK_HALF_CYC - 1));
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			blink_cnt_reg <= 32'h0000_0000;
			blink_reg <= 1'b0;
		end else begin
			blink_cnt_reg <= blink_wrap ? 32'h0000_0000 :
				blink_cnt_reg + 32'h0000_0001;
			if (blink_wrap) begin
				blink_reg <= ~blink_reg;
			end
		end
	end

	// restart operators, plain or macro, manual or monitored
	// wait: no restart seen; armed: monitored pulse is high;
	// set: latched until a clear or a false condition
	// no upper limit on pulse length: a held button leaves it armed
	genvar gi;
	generate
		for (gi = 0; gi < LRO_RST_N; gi++) begin : g_rst
			wire [LRO_RC_W-1:0] cfg = rcfg_reg[gi];
			wire cond = lro_gate(rst_cond_in[gi*LRO_GATE_W +: LRO_GATE_W],
				cfg[LRO_RC_CN_LSB +: 3], cfg[LRO_RC_CF_LSB +: 3]);
			wire cmd = LRO_ENHANCED ?
				lro_gate(rst_cmd_in[gi*LRO_GATE_W +: LRO_GATE_W],
				cfg[LRO_RC_RN_LSB +: 3], cfg[LRO_RC_RF_LSB +: 3]) :
				rst_cmd_in[gi*LRO_GATE_W];
			logic cmd_prev_reg;
			lro_rst_state_t st_reg;
			lro_rst_state_t st_next;
			logic q_reg;
			logic req_reg;
			logic cout_reg;
			wire cmd_rise = cmd & ~cmd_prev_reg;
			wire cmd_fall = ~cmd & cmd_prev_reg;
			// clear counts only when its input is enabled
			wire blocked = (cfg[LRO_RC_CLR_EN] & rst_clear_in[gi]) | ~cond;
			wire monitored = cfg[LRO_RC_MON];
			wire is_set = (st_next == LRO_RS_SET);
			// style one is high only while waiting; two is high while blocked and blinks while waiting
			wire req_next = !cfg[LRO_RC_REQ_EN] ? 1'b0 :
				cfg[LRO_RC_STYLE2] ?
				(blocked | (~is_set & blink_reg)) :
				(~blocked & ~is_set);

			always_comb begin
				st_next = st_reg;
				case (st_reg)
					LRO_RS_WAIT: begin
						if (cmd_rise) begin
							st_next = monitored ? LRO_RS_ARMED : LRO_RS_SET;
						end
					end
					LRO_RS_ARMED: begin
						// pulse completes only on its falling half
						if (cmd_fall) begin
							st_next = LRO_RS_SET;
						end
					end
					LRO_RS_SET: st_next = LRO_RS_SET;
					default: st_next = LRO_RS_WAIT;
				endcase
				if (blocked) begin
					st_next = LRO_RS_WAIT;
				end
			end

			always_ff @(posedge sys_clk or negedge rstn) begin
				if (!rstn) begin
					cmd_prev_reg <= 1'b0;
					st_reg <= LRO_RS_WAIT;
					q_reg <= 1'b0;
					req_reg <= 1'b0;
					cout_reg <= 1'b0;
				end else if (!boot_reg) begin
					cmd_prev_reg <= cmd;
					st_reg <= st_next;
					q_reg <= is_set;
					req_reg <= req_next;
					cout_reg <= cfg[LRO_RC_OUT_EN] & cond;
				end
			end
			assign rst_q[gi] = q_reg;
			assign rst_req[gi] = req_reg;
			assign rst_cond_out[gi] = cout_reg;
		end
	endgenerate

	// hsize is not decoded: only whole-word transfers are used
	wire unused_ok = &{1'b0, hsize, haddr[1:0]};

endmodule

// file: src/lro_pkg.sv
// shared constants and types for the latch and restart operator block
package lro_pkg;

	// instance counts
	localparam int LRO_DFF_N = 16;
	localparam int LRO_TFF_N = 16;
	localparam int LRO_SR_N = 16;
	localparam bit LRO_ENHANCED = 1'b1;
	localparam int LRO_RST_N = LRO_ENHANCED ? 32 : 16;
	localparam int LRO_GATE_W = 7;

	// clock and blink timing
	localparam longint LRO_CLK_PERIOD_NS = 4;
	localparam longint LRO_BLINK_PERIOD_NS = 1000000000;
	localparam longint LRO_BLINK_HALF_CYC =
		(LRO_BLINK_PERIOD_NS / 2) / LRO_CLK_PERIOD_NS;

	// register byte offsets and the restart configuration block number
	localparam logic [11:0] LRO_DFF_CFG_OFS = 12'h000;
	localparam logic [11:0] LRO_TFF_CFG_OFS = 12'h004;
	localparam logic [11:0] LRO_SR_CFG_OFS = 12'h008;
	localparam logic [11:0] LRO_DFF_Q_OFS = 12'h00c;
	localparam logic [11:0] LRO_TFF_Q_OFS = 12'h010;
	localparam logic [11:0] LRO_SR_Q_OFS = 12'h014;
	localparam logic [11:0] LRO_RST_Q_OFS = 12'h018;
	localparam logic [11:0] LRO_RST_REQ_OFS = 12'h01c;
	localparam logic [11:0] LRO_RST_CFG_OFS = 12'h100;
	localparam logic [4:0] LRO_RST_CFG_BLK = 5'h02;

	// restart configuration word fields
	localparam int LRO_RC_CN_LSB = 0;
	localparam int LRO_RC_CF_LSB = 3;
	localparam int LRO_RC_RN_LSB = 6;
	localparam int LRO_RC_RF_LSB = 9;
	localparam int LRO_RC_MON = 12;
	localparam int LRO_RC_CLR_EN = 13;
	localparam int LRO_RC_REQ_EN = 14;
	localparam int LRO_RC_STYLE2 = 15;
	localparam int LRO_RC_OUT_EN = 16;
	localparam int LRO_RC_W = 17;

	// reset values
	localparam logic [31:0] LRO_CFG_RST = 32'h0000_0000;
	localparam logic [LRO_RC_W-1:0] LRO_RC_RST = 17'h0_0041;

	typedef enum logic [2:0] {
		LRO_G_AND = 3'h0,
		LRO_G_NAND = 3'h1,
		LRO_G_OR = 3'h2,
		LRO_G_NOR = 3'h3,
		LRO_G_XOR = 3'h4,
		LRO_G_XNOR = 3'h5
	} lro_gate_fn_t;

	// gray along off/wait -> armed -> set
	typedef enum logic [1:0] {
		LRO_RS_WAIT = 2'b00,
		LRO_RS_ARMED = 2'b01,
		LRO_RS_SET = 2'b11
	} lro_rst_state_t;

endpackage

// file: sim/lro_core_properties.sv
// port checker of the latch and restart operator block
`timescale 1ns/1ps
module lro_chk import lro_pkg::*; (
	input wire logic sys_clk, // clock
	input wire logic rstn, // reset, active low
	input wire logic hreadyout, // slave ready
	input wire logic hresp, // response
	input wire logic [LRO_DFF_N-1:0] dff_data_in, // data
	input wire logic [LRO_DFF_N-1:0] capture_edge_in, // capture
	input wire logic [LRO_DFF_N-1:0] dff_preset_in, // preset
	input wire logic [LRO_DFF_N-1:0] dff_clear_in, // clear
	input wire logic [LRO_DFF_N-1:0] dff_q, // data ff out
	input wire logic [LRO_TFF_N-1:0] tff_toggle_in, // toggle
	input wire logic [LRO_TFF_N-1:0] tff_clear_in, // toggle clear
	input wire logic [LRO_TFF_N-1:0] tff_q, // toggle out
	input wire logic [LRO_SR_N-1:0] sr_set_in, // set
	input wire logic [LRO_SR_N-1:0] sr_reset_in, // reset
	input wire logic [LRO_SR_N-1:0] sr_q, // latch out
	input wire logic nv_write, // store strobe
	input wire logic [LRO_RST_N*LRO_GATE_W-1:0] rst_cond_in, // cond
	input wire logic [LRO_RST_N*LRO_GATE_W-1:0] rst_cmd_in, // restart
	input wire logic [LRO_RST_N-1:0] rst_clear_in, // restart clear
	input wire logic [LRO_RST_N-1:0] rst_q, // restart out
	input wire logic [LRO_RST_N-1:0] rst_req // request out
);
	// restart 0 must stay manual, counts 1, clear enabled before use
	logic [1:0] age_reg;
	wire ok = age_reg == 2'd3;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// skip the first three cycles after reset: the boot cycle, whose edge history is still from reset, and the two after it
	always_ff @(posedge sys_clk or negedge rstn)
		if (!rstn) age_reg <= 2'd0;
		else if (!ok) age_reg <= age_reg + 2'd1;
	property p_bus;
		hreadyout && !hresp;
	endproperty
	a_bus: assert property (p_bus)
		else $error("bus answer not ready or not okay");
	property p_dff;
		ok && $rose(capture_edge_in[0]) && !dff_preset_in[0]
		&& !dff_clear_in[0] |=> dff_q[0] == $past(dff_data_in[0]);
	endproperty
	a_dff: assert property (p_dff)
		else $error("data flip-flop missed a capture");
	property p_tff;
		ok && $rose(tff_toggle_in[0]) && !tff_clear_in[0]
		|=> $changed(tff_q[0]);
	endproperty
	a_tff: assert property (p_tff)
		else $error("toggle output did not invert");
	property p_sr;
		ok && (sr_set_in[0] || sr_reset_in[0])
		|=> sr_q[0] == ($past(sr_set_in[0]) && !$past(sr_reset_in[0]));
	endproperty
	a_sr: assert property (p_sr)
		else $error("latch not reset dominant");
	property p_nv;
		nv_write |-> $past(sr_q) != $past(sr_q, 2) || sr_q != $past(sr_q);
	endproperty
	a_nv: assert property (p_nv)
		else $error("store strobe without a latch change");
	property p_blk;
		ok && (!rst_cond_in[0] || rst_clear_in[0]) |=> !rst_q[0];
	endproperty
	a_blk: assert property (p_blk)
		else $error("blocked restart output not low");
	sequence s_arm;
		!rst_cmd_in[0] ##1
		(ok && rst_cmd_in[0] && rst_cond_in[0] && !rst_clear_in[0]);
	endsequence
	property p_set;
		s_arm |=> rst_q[0];
	endproperty
	a_set: assert property (p_set)
		else $error("restart edge did not set output");
	property p_req;
		(rst_req & rst_q) == '0;
	endproperty
	a_req: assert property (p_req)
		else $error("request high with output set");
endmodule
bind lro_core lro_chk u_chk (.sys_clk, .rstn, .hreadyout, .hresp,
	.dff_data_in, .capture_edge_in, .dff_preset_in, .dff_clear_in,
	.dff_q, .tff_toggle_in, .tff_clear_in, .tff_q, .sr_set_in,
	.sr_reset_in, .sr_q, .nv_write, .rst_cond_in, .rst_cmd_in,
	.rst_clear_in, .rst_q, .rst_req);

// file: sim/lro_restart_button.sv
// restart pushbutton model feeding a monitored restart input
`timescale 1ns/1ps
module lro_restart_button (
	input wire logic sys_clk, // clock
	input wire logic rstn, // reset, active low
	input wire logic press, // request one stroke
	input wire logic [7:0] hold, // cycles held high
	output logic btn // contact level, idle low
);
	logic [7:0] cnt_reg;
	// whole low-high-low stroke; presses while held are ignored
	always_ff @(posedge sys_clk or negedge rstn)
		if (!rstn) cnt_reg <= 8'h00;
		else if (cnt_reg != 8'h00) cnt_reg <= cnt_reg - 8'h01;
		else if (press) cnt_reg <= hold;
	assign btn = cnt_reg != 8'h00;
endmodule

// file: sim/tb_latch_and_restart_operators.sv
// self-checking bench of the latch and restart operator block
`timescale 1ns/1ps
module tb_latch_and_restart_operators import lro_pkg::*; ;
	localparam int ZW = LRO_RST_N * LRO_GATE_W - 32;
	// stored latch image reloaded at every boot
	localparam logic [15:0] IMG = 16'ha5a5;
	logic sys_clk = 1'b0, rstn = 1'b0, hwrite = 1'b0, press = 1'b0, b;
	logic [1:0] htrans = 2'b00;
	logic [7:0] hold = 8'd12;
	logic [31:0] haddr = '0, hwdata = '0, rd, cv = '0, mv = '0, kv = '0;
	logic [31:0] seed = 32'hff010f6b;
	logic [15:0] dd = '0, dk = '0, dp = '0, dc = '0, td = '0, tc = '0;
	logic [15:0] ss = '0, rs = '0, m_dq = '0, m_tq = '0, m_sq = IMG;
	logic [15:0] s1 = '0, pk = '0, pt = '0;
	logic m_rq = 1'b0, pm = 1'b0;
	wire hreadyout, hresp, nv_write, btn;
	wire [31:0] hrdata, rst_q, rst_req, rst_cond_out;
	wire [15:0] dff_q, tff_q, sr_q, nv_write_data;
	int errors = 0, n_compared = 0, cyc = 0, n;
	lro_restart_button u_btn (.sys_clk, .rstn, .press, .hold, .btn);
	lro_core #(.BLINK_HALF_CYC(4)) dut (.sys_clk, .rstn, .hsel(1'b1),
		.haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.dff_data_in(dd), .capture_edge_in(dk), .dff_preset_in(dp),
		.dff_clear_in(dc), .dff_q, .tff_toggle_in(td), .tff_clear_in(tc),
		.tff_q, .sr_set_in(ss), .sr_reset_in(rs), .sr_q,
		.nv_restore_in(IMG), .nv_write, .nv_write_data,
		.rst_cond_in({{ZW{1'b0}}, cv}),
		.rst_cmd_in({{ZW{1'b0}}, mv[31:8], btn, mv[6:0]}),
		.rst_clear_in(kv), .rst_q, .rst_req, .rst_cond_out);
	always #2 sys_clk = ~sys_clk;
	task automatic wrap_up();
		$display("errors=%0d compared=%0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			wrap_up();
		end
	end
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction
	function automatic logic gfn(input logic [2:0] f, input logic [2:0] v);
		case (f)
			LRO_G_AND: return &v;
			LRO_G_NAND: return ~&v;
			LRO_G_OR: return |v;
			LRO_G_NOR: return ~|v;
			LRO_G_XOR: return ^v;
			default: return ~^v;
		endcase
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// entered at a rising edge; waits for hready in both phases
	task automatic bus(input logic [11:0] a, input logic w,
		input logic [31:0] d);
		haddr <= {20'h0, a};
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	// model this edge from the sampled inputs, then drive the next ones
	task automatic step();
		logic [15:0] kr, tr;
		logic chg;
		kr = dk & ~pk;
		tr = td & ~pt;
		m_dq = ~dc & (dp | (kr & dd) | (~kr & m_dq));
		m_tq = ~tc & (m_tq ^ tr);
		s1 = m_sq;
		m_sq = ~rs & (ss | m_sq);
		chg = m_sq != s1;
		b = kv[0] | ~cv[0];
		m_rq = ~b & (m_rq | (mv[0] & ~pm));
		{pk, pt, pm} = {dk, td, mv[0]};
		seed = xs(seed);
		{dd, dk} <= seed;
		seed = xs(seed);
		{td, ss} <= seed;
		seed = xs(seed);
		dp <= seed[15:0] & seed[31:16];
		tc <= seed[15:0] & seed[30:15];
		seed = xs(seed);
		dc <= seed[15:0] & seed[31:16];
		rs <= seed[15:0] & seed[29:14];
		seed = xs(seed);
		cv <= seed | (seed >> 3);
		kv <= seed & (seed >> 5) & (seed >> 9);
		seed = xs(seed);
		mv <= seed;
		#1 chk({dff_q, tff_q}, {m_dq, m_tq});
		chk({sr_q, 15'h0, nv_write}, {m_sq, 15'h0, chg});
		if (chg) chk({16'h0, nv_write_data}, {16'h0, m_sq});
		chk(32'({rst_q[0], rst_req[0]}), 32'({m_rq, ~b & ~m_rq}));
	endtask
	initial begin
		repeat (3) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		bus(LRO_RST_CFG_OFS + 12'h080, 1'b0, '0);
		chk(rd, '0);
		bus(LRO_RST_CFG_OFS, 1'b0, '0);
		chk(rd, 32'(LRO_RC_RST));
		bus(LRO_DFF_CFG_OFS, 1'b1, '1);
		bus(LRO_TFF_CFG_OFS, 1'b1, 32'hffff);
		bus(LRO_SR_CFG_OFS, 1'b1, 32'hffff);
		bus(LRO_RST_CFG_OFS, 1'b1, 32'h6041);
		bus(LRO_RST_CFG_OFS + 12'h004, 1'b1, 32'hd041);
		bus(LRO_SR_CFG_OFS, 1'b0, '0);
		chk(rd, 32'hffff);
		// store count bounded by the step count
		repeat (300) begin
			@(posedge sys_clk);
			step();
		end
		@(posedge sys_clk);
		kv <= '0;
		ss <= '0;
		rs <= '0;
		for (int f = 0; f < 6; f++) begin
			bus(LRO_RST_CFG_OFS + 12'h008, 1'b1, 32'h10043 | (32'(f) << 3));
			for (int v = 0; v < 8; v++) begin
				cv <= 32'(v) << 14;
				@(posedge sys_clk);
				#1 chk(32'(rst_cond_out[2]), 32'(gfn(f[2:0], v[2:0])));
				@(posedge sys_clk);
			end
		end
		cv <= '0;
		mv <= '0;
		repeat (2) @(posedge sys_clk);
		#1 chk(32'({rst_q[1], rst_req[1]}), 32'h1);
		@(posedge sys_clk);
		cv <= 32'h80;
		repeat (2) @(posedge sys_clk);
		n = 0;
		repeat (16) begin
			#1 n += (rst_req[1] === 1'b1);
			@(posedge sys_clk);
		end
		chk(32'(n), 32'h8);
		// a long stroke must not set on its rising edge; a short one sets
		for (int i = 0; i < 2; i++) begin
			hold <= i ? 8'd1 : 8'd12;
			press <= 1'b1;
			cv <= 32'h80;
			@(posedge sys_clk);
			press <= 1'b0;
			repeat (7) @(posedge sys_clk);
			#1 chk(32'(rst_q[1]), 32'(i));
			repeat (10) @(posedge sys_clk);
			#1 chk(32'({rst_q[1], rst_req[1]}), 32'h2);
			@(posedge sys_clk);
			cv <= '0;
			repeat (2) @(posedge sys_clk);
			#1 chk(32'({rst_q[1], rst_req[1]}), 32'h1);
			@(posedge sys_clk);
		end
		rstn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1 chk({dff_q, tff_q}, '0);
		chk({sr_q, rst_q[15:0]}, '0);
		@(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		bus(LRO_SR_CFG_OFS, 1'b0, '0);
		chk(rd, '0);
		chk({16'h0, sr_q}, 32'(IMG));
		wrap_up();
	end
endmodule
